/* core/rts_pkg.sv */
// Constants and types shared by the reset time-out sequencer
package rts_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_FREQ_KHZ = 200_000;
    localparam int POWER_UP_TIMER_TIME_MS = 96;
    localparam int POWER_UP_TIMER_W = 25;
    localparam logic [POWER_UP_TIMER_W-1:0] POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_W'(POWER_UP_TIMER_TIME_MS * CLK_FREQ_KHZ);
    localparam int OST_W = 11;
    localparam logic [OST_W-1:0] OST_PULSES = 11'h0400;

    // ****************************************************************
    // Reset values and field layout
    // ****************************************************************
    localparam int PC_W = 16;
    localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
    localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
    localparam logic STAT_FIXED_BIT = 1'b1;
    localparam logic GLOBAL_INTERRUPT_DISABLE_RESET = 1'b1;

    // ****************************************************************
    // Oscillator modes
    // ****************************************************************
    localparam logic [1:0] OSC_CRYSTAL = 2'h0;
    localparam logic [1:0] OSC_LOW_FREQ = 2'h1;
    localparam logic [1:0] OSC_EXT_CLOCK = 2'h2;
    localparam logic [1:0] OSC_RES_CAP = 2'h3;

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_MASTER_CLEAR_N = 3'b001,
        ST_TIME = 3'b010,
        ST_RUN = 3'b011,
        ST_SLEEP = 3'b100
    } rts_state_t;

endpackage : rts_pkg

/* core/rts_sequencer.sv */
// Reset and wake-up time-out sequencer top level
// Overview of operation
// - Start-up counter holds reset for 1024 oscillator periods after release or wake.
// - Start-up delay on power-on in every mode; on exit from sleep only in crystal or low-frequency modes.
// - Count oscillator pin pulses only once signal amplitude is adequate.
// - After power-on trip with master clear high, both timers start together.
// - Power-up wait is longer of 96 ms and 1024 periods; master clear in run adds none.
// - Time-out counting restarts at every rising edge of master clear.
// - Time-out and power-down flags encode the reset or wake cause.
// - Every reset loads the program counter with zero.
// - Status value per reset cause: 1111, 1110, 1101 or 1100.
// - Interrupt wake advances program counter; status 1110 or 1010 by interrupt disable.
// - Wake with interrupts enabled runs next instruction, then the interrupt vector.
// - Start-up counter skips master clear and watchdog resets while running.
`timescale 1ns/1ps
module rts_sequencer #(
    parameter logic [rts_pkg::POWER_UP_TIMER_W-1:0] POWER_UP_TIMER_CYCLES = rts_pkg::POWER_UP_TIMER_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic por_in,
    input wire logic master_clear_n_in,
    input wire logic osc_input_pin_in,
    input wire logic osc_amp_ok_in,
    input wire logic [1:0] osc_mode_in,
    input wire logic sleep_instr_in,
    input wire logic wake_int_in,
    input wire logic watchdog_timeout_in,
    input wire logic watchdog_clear_instr_in,
    input wire logic global_interrupt_disable_in,
    input wire logic instr_done_in,
    input wire logic [rts_pkg::PC_W-1:0] pc_in,
    output logic core_reset_out,
    output logic wake_hold_out,
    output logic pc_load_out,
    output logic [rts_pkg::PC_W-1:0] program_counter_out,
    output logic timeout_flag_out,
    output logic powerdown_flag_out,
    output logic [3:0] cpu_status_out,
    output logic int_vector_due_out
);
    // ****************************************************************
    // State and event decode
    // ****************************************************************
    rts_pkg::rts_state_t state_r;
    rts_pkg::rts_state_t state_nxt;
    logic need_power_up_timer_r;
    logic need_ost_r;
    logic wake_r;
    logic to_r;
    logic pd_r;
    logic global_interrupt_disable_r;
    logic vec_due_r;
    logic [rts_pkg::PC_W-1:0] pc_r;
    logic osc_prev_r;
    logic osc_tick;
    logic power_up_timer_done;
    logic ost_done;
    logic timers_done;
    logic slow_osc;
    logic ev_master_clear_n;
    logic ev_wdt;
    logic ev_wake;

    assign slow_osc = (osc_mode_in == rts_pkg::OSC_CRYSTAL) || (osc_mode_in == rts_pkg::OSC_LOW_FREQ);
    // Priority: power loss, then master clear, then watchdog, then wake
    assign ev_master_clear_n = por_in && !master_clear_n_in && (state_r == rts_pkg::ST_RUN || state_r == rts_pkg::ST_SLEEP);
    assign ev_wdt = por_in && master_clear_n_in && watchdog_timeout_in
                    && (state_r == rts_pkg::ST_RUN || state_r == rts_pkg::ST_SLEEP);
    assign ev_wake = por_in && master_clear_n_in && !watchdog_timeout_in && wake_int_in
                     && state_r == rts_pkg::ST_SLEEP;

    // ****************************************************************
    // Timers
    // ****************************************************************
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            osc_prev_r <= 1'b0;
        else
            osc_prev_r <= osc_input_pin_in;
    end

    assign osc_tick = osc_input_pin_in && !osc_prev_r && osc_amp_ok_in;

    // Both timers clear outside the timing state, so they start on the same edge
    rts_timer #(.W(rts_pkg::OST_W)) u_ost (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .clr_in(state_r != rts_pkg::ST_TIME),
        .tick_in(osc_tick),
        .limit_in(rts_pkg::OST_PULSES),
        .done_out(ost_done)
    );

    rts_timer #(.W(rts_pkg::POWER_UP_TIMER_W)) u_power_up_timer (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .clr_in(state_r != rts_pkg::ST_TIME),
        .tick_in(1'b1),
        .limit_in(POWER_UP_TIMER_CYCLES),
        .done_out(power_up_timer_done)
    );

    assign timers_done = (power_up_timer_done || !need_power_up_timer_r) && (ost_done || !need_ost_r);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            rts_pkg::ST_OFF:
                if (por_in)
                    state_nxt = master_clear_n_in ? rts_pkg::ST_TIME : rts_pkg::ST_MASTER_CLEAR_N;
            rts_pkg::ST_MASTER_CLEAR_N:
                if (master_clear_n_in)
                    state_nxt = rts_pkg::ST_TIME;
            rts_pkg::ST_TIME:
                if (!master_clear_n_in)
                    state_nxt = rts_pkg::ST_MASTER_CLEAR_N;
                else if (timers_done)
                    state_nxt = rts_pkg::ST_RUN;
            rts_pkg::ST_RUN:
                if (ev_master_clear_n)
                    state_nxt = rts_pkg::ST_MASTER_CLEAR_N;
                else if (ev_wdt)
                    state_nxt = rts_pkg::ST_TIME;
                else if (sleep_instr_in)
                    state_nxt = rts_pkg::ST_SLEEP;
            rts_pkg::ST_SLEEP:
                if (ev_master_clear_n)
                    state_nxt = rts_pkg::ST_MASTER_CLEAR_N;
                else if (ev_wdt || ev_wake)
                    state_nxt = rts_pkg::ST_TIME;
            default:
                state_nxt = rts_pkg::ST_OFF;
        endcase
        if (!por_in)
            state_nxt = rts_pkg::ST_OFF;
    end

    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            state_r <= rts_pkg::ST_OFF;
        else
            state_r <= state_nxt;
    end

    // Which timers the pending release must wait for
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            need_power_up_timer_r <= 1'b1;
            need_ost_r <= 1'b1;
            wake_r <= 1'b0;
        end
        else if (!por_in)
        begin
            // Start-up count applies on power-up in every mode to meet the longer-of wait
            need_power_up_timer_r <= 1'b1;
            need_ost_r <= 1'b1;
            wake_r <= 1'b0;
        end
        else if (ev_master_clear_n || ev_wdt || ev_wake)
        begin
            need_power_up_timer_r <= 1'b0;
            need_ost_r <= (state_r == rts_pkg::ST_SLEEP) && slow_osc;
            wake_r <= ev_wake;
        end
    end

    // ****************************************************************
    // Status flags and program counter
    // ****************************************************************
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            to_r <= 1'b1;
            pd_r <= 1'b1;
            global_interrupt_disable_r <= rts_pkg::GLOBAL_INTERRUPT_DISABLE_RESET;
        end
        else if (!por_in)
        begin
            to_r <= 1'b1;
            pd_r <= 1'b1;
            global_interrupt_disable_r <= rts_pkg::GLOBAL_INTERRUPT_DISABLE_RESET;
        end
        else if (ev_master_clear_n)
        begin
            to_r <= 1'b1;
            pd_r <= (state_r == rts_pkg::ST_RUN);
            global_interrupt_disable_r <= rts_pkg::GLOBAL_INTERRUPT_DISABLE_RESET;
        end
        else if (ev_wdt)
        begin
            to_r <= 1'b0;
            pd_r <= (state_r == rts_pkg::ST_RUN);
            global_interrupt_disable_r <= rts_pkg::GLOBAL_INTERRUPT_DISABLE_RESET;
        end
        else if (ev_wake)
        begin
            to_r <= 1'b1;
            pd_r <= 1'b0;
            global_interrupt_disable_r <= global_interrupt_disable_in;
        end
        else if (state_r == rts_pkg::ST_RUN && sleep_instr_in)
        begin
            to_r <= 1'b1;
            pd_r <= 1'b0;
        end
        else if (state_r == rts_pkg::ST_RUN && watchdog_clear_instr_in)
        begin
            to_r <= 1'b1;
            pd_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            pc_r <= rts_pkg::PC_RESET;
        else if (!por_in || !master_clear_n_in || ev_wdt)
            pc_r <= rts_pkg::PC_RESET;
        else if (ev_wake)
            pc_r <= pc_in + rts_pkg::PC_STEP;
    end

    // Vector is due after the one instruction that follows sleep
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            vec_due_r <= 1'b0;
        else if (!por_in || ev_master_clear_n || ev_wdt)
            vec_due_r <= 1'b0;
        else if (ev_wake)
            vec_due_r <= !global_interrupt_disable_in;
        else if (state_r == rts_pkg::ST_RUN && instr_done_in)
            vec_due_r <= 1'b0;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign core_reset_out = (state_r == rts_pkg::ST_OFF) || (state_r == rts_pkg::ST_MASTER_CLEAR_N)
                            || (state_r == rts_pkg::ST_TIME && !wake_r);
    assign wake_hold_out = (state_r == rts_pkg::ST_TIME) && wake_r;
    assign pc_load_out = (state_r == rts_pkg::ST_TIME) && (state_nxt == rts_pkg::ST_RUN);
    assign program_counter_out = pc_r;
    assign timeout_flag_out = to_r;
    assign powerdown_flag_out = pd_r;
    assign cpu_status_out = {rts_pkg::STAT_FIXED_BIT, global_interrupt_disable_r, to_r, pd_r};
    assign int_vector_due_out = vec_due_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_power_loss_reset: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !por_in |=> core_reset_out && timeout_flag_out && powerdown_flag_out)
        else $error("power loss did not hold reset");

    a_clear_low_reset: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (por_in && !master_clear_n_in) |=> core_reset_out && program_counter_out == rts_pkg::PC_RESET)
        else $error("master clear low did not reset");

    a_power_up_timer_wait: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state_r == rts_pkg::ST_TIME && need_power_up_timer_r && !power_up_timer_done) |=> state_r != rts_pkg::ST_RUN)
        else $error("released before power-up timer expired");

    a_ost_wait: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state_r == rts_pkg::ST_TIME && need_ost_r && !ost_done) |=> state_r != rts_pkg::ST_RUN)
        else $error("released before start-up count expired");

    a_wdt_run_flags: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state_r == rts_pkg::ST_RUN && ev_wdt) |=> !timeout_flag_out && powerdown_flag_out && core_reset_out)
        else $error("watchdog run flags wrong");

    a_wdt_sleep_stat: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state_r == rts_pkg::ST_SLEEP && ev_wdt) |=> cpu_status_out == 4'b1100 && need_ost_r == $past(slow_osc))
        else $error("watchdog sleep status wrong");

    a_wake_pc_step: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        ev_wake |=> program_counter_out == $past(pc_in) + rts_pkg::PC_STEP
                    && cpu_status_out[2] == $past(global_interrupt_disable_in) && wake_hold_out)
        else $error("wake program counter or status wrong");

    a_vector_after: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (ev_wake && !global_interrupt_disable_in) |=> int_vector_due_out)
        else $error("interrupt vector not marked due");

    a_master_clear_n_run_fast: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state_r == rts_pkg::ST_MASTER_CLEAR_N && master_clear_n_in && por_in && !need_power_up_timer_r && !need_ost_r)
        ##1 (por_in && master_clear_n_in) |=> !core_reset_out)
        else $error("master clear in run added a time-out");

    a_mode_gate: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        ((ev_wake || ev_wdt || ev_master_clear_n) && !slow_osc) |=> !need_ost_r && !need_power_up_timer_r)
        else $error("start-up count used in fast clock mode");
endmodule : rts_sequencer

/* core/rts_timer.sv */
// Saturating event counter with a programmable terminal count
`timescale 1ns/1ps
module rts_timer #(
    parameter int W = 8
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic clr_in,
    input wire logic tick_in,
    input wire logic [W-1:0] limit_in,
    output logic done_out
);
    logic [W-1:0] count_r;

    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            count_r <= '0;
        else if (clr_in)
            count_r <= '0;
        else if (tick_in && !done_out)
            count_r <= count_r + W'(1);
    end

    assign done_out = (count_r >= limit_in);
endmodule : rts_timer

/* tb/rts_osc_model.sv */
// Behavioural crystal oscillator and master clear RC circuit
`timescale 1ns/1ps
module rts_osc_model #(
    parameter int MASTER_CLEAR_N_DLY = 6
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic slow_in,
    input wire logic button_n_in,
    output logic osc_pin_out,
    output logic amp_ok_out,
    output logic master_clear_n_out
);
    logic div_r;
    logic [4:0] amp_cnt_r;
    logic [3:0] rc_cnt_r;

    // ****************************************************************
    // Oscillator: pulse every 2 cycles, or every 4 when slow
    // ****************************************************************
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            div_r <= 1'b0;
            osc_pin_out <= 1'b0;
        end
        else
        begin
            div_r <= ~div_r;
            if (!slow_in || div_r)
            begin
                osc_pin_out <= ~osc_pin_out;
            end
        end
    end

    // Amplitude builds up over 16 pulses, so early pulses must not count
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            amp_cnt_r <= 5'h00;
        end
        else if (!amp_cnt_r[4] && !osc_pin_out && (!slow_in || div_r))
        begin
            amp_cnt_r <= amp_cnt_r + 5'h01;
        end
    end
    assign amp_ok_out = amp_cnt_r[4];

    // ****************************************************************
    // Master clear: falls at once, rises after an RC delay
    // ****************************************************************
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rc_cnt_r <= 4'h0;
        end
        else if (!button_n_in)
        begin
            rc_cnt_r <= 4'h0;
        end
        else if (32'(rc_cnt_r) < MASTER_CLEAR_N_DLY)
        begin
            rc_cnt_r <= rc_cnt_r + 4'h1;
        end
    end
    assign master_clear_n_out = (32'(rc_cnt_r) >= MASTER_CLEAR_N_DLY);
endmodule : rts_osc_model

/* tb/rts_sequencer_tb_top.sv */
// Self-checking testbench of the reset time-out sequencer
`timescale 1ns/1ps
module rts_sequencer_tb_top;
    localparam int DLY = 6;
    logic clk = 1'b0, rstn = 1'b0, por = 1'b0, btn_n = 1'b1, slow = 1'b0, slp = 1'b0, wake = 1'b0;
    logic wdt = 1'b0, wdclr = 1'b0, gid = 1'b1, idone = 1'b0, g, seen;
    logic [1:0] mode = 2'h0;
    logic [15:0] pc_in = 16'h0000, pcv, pc_out;
    logic master_clear_n_n, osc_pin, amp_ok, creset, whold, pc_load, to, pd, vec;
    logic [3:0] stat;
    int error_cnt = 0, check_count = 0, n, per, lo, hi;

    rts_osc_model #(.MASTER_CLEAR_N_DLY(DLY)) rts_osc_model_i (.core_clk_in(clk), .rstn_in(rstn), .slow_in(slow),
        .button_n_in(btn_n), .osc_pin_out(osc_pin), .amp_ok_out(amp_ok), .master_clear_n_out(master_clear_n_n));
    // Timer shortened so both the timer and the pulse count can dominate
    rts_sequencer #(.POWER_UP_TIMER_CYCLES(25'h0bb8)) rts_sequencer_i (.core_clk_in(clk), .rstn_in(rstn), .por_in(por),
        .master_clear_n_in(master_clear_n_n), .osc_input_pin_in(osc_pin), .osc_amp_ok_in(amp_ok), .osc_mode_in(mode),
        .sleep_instr_in(slp), .wake_int_in(wake), .watchdog_timeout_in(wdt), .watchdog_clear_instr_in(wdclr),
        .global_interrupt_disable_in(gid), .instr_done_in(idone), .pc_in(pc_in), .core_reset_out(creset),
        .wake_hold_out(whold), .pc_load_out(pc_load), .program_counter_out(pc_out), .timeout_flag_out(to),
        .powerdown_flag_out(pd), .cpu_status_out(stat), .int_vector_due_out(vec));

    // ****************************************************************
    // Tasks and expectations
    // ****************************************************************
    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic test_done();
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input int v, input int l, input int h);
        check_count++;
        if (v < l || v > h)
        begin
            error_cnt++;
            $display("Error at %0t: hold %h outside %h to %h", $time, v, l, h);
        end
    endtask : chk_rng

    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    // Counts held cycles; bounded so a stuck sequencer ends the run
    task automatic wait_rel(output int cnt, output logic pl);
        cnt = 0;
        pl = 1'b0;
        while ((creset !== 1'b0 || whold !== 1'b0) && cnt < 20000)
        begin
            pl = pl | (pc_load === 1'b1);
            step();
            cnt++;
        end
        if (cnt >= 20000)
        begin
            error_cnt++;
            test_done();
        end
    endtask : wait_rel

    function automatic logic [3:0] exp_stat(input int kind, input logic gd);
        if (kind == 0)
            return {1'b1, gd, 2'b10};
        return (kind == 1) ? 4'hc : 4'he;
    endfunction : exp_stat

    initial
    begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        test_done();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        void'($urandom(32'hada0));
        repeat (4) @(posedge clk);
        #1 rstn = 1'b1;
        slow = 1'($urandom_range(1, 0));
        mode = 2'($urandom_range(3, 0));
        btn_n = 1'b0;
        per = slow ? 4 : 2;
        step();
        por = 1'b1;
        repeat ($urandom_range(9, 2)) step();
        chk(16'(creset), 16'h0001);
        btn_n = 1'b1;
        wait_rel(n, seen);
        lo = (1023 * per > 3000) ? 1023 * per : 3000;
        hi = ((1025 * per > 3000) ? 1025 * per : 3000) + 16 * per + DLY + 4;
        chk_rng(n, lo, hi);
        chk(16'(seen), 16'h0001);
        chk(16'({to, pd}), 16'h0003);
        chk(16'(stat), 16'h000f);
        chk(pc_out, 16'h0000);
        // Watchdog in run, then clear instruction
        wdt = 1'b1;
        step();
        wdt = 1'b0;
        chk(16'(stat), 16'h000d);
        wait_rel(n, seen);
        chk(16'(n), 16'h0001);
        wdclr = 1'b1;
        step();
        wdclr = 1'b0;
        chk(16'({to, pd}), 16'h0003);
        // Master clear in run adds no wait beyond the RC rise
        btn_n = 1'b0;
        repeat (3) step();
        chk(16'({creset, stat}), 16'h001f);
        btn_n = 1'b1;
        wait_rel(n, seen);
        chk_rng(n, 1, DLY + 4);
        // Sleep exits: wake, watchdog, master clear in every mode
        for (int m = 0; m < 4; m++)
        begin
            for (int k = 0; k < 3; k++)
            begin
                mode = 2'(m);
                g = 1'($urandom_range(1, 0));
                pcv = 16'($urandom());
                gid = g;
                pc_in = pcv;
                slp = 1'b1;
                step();
                slp = 1'b0;
                chk(16'({creset, to, pd}), 16'h0002);
                wake = (k == 0);
                wdt = (k == 1);
                btn_n = (k != 2);
                repeat ((k == 2) ? 3 : 1) step();
                wake = 1'b0;
                wdt = 1'b0;
                btn_n = 1'b1;
                chk(16'({creset, whold}), (k == 0) ? 16'h0001 : 16'h0002);
                chk(16'(stat), 16'(exp_stat(k, g)));
                chk(pc_out, (k == 0) ? pcv + 16'h0001 : 16'h0000);
                per = slow ? 4 : 2;
                wait_rel(n, seen);
                lo = (m < 2) ? 1023 * per : 1;
                hi = ((m < 2) ? 1025 * per : 1) + DLY + 4;
                chk_rng(n, lo, hi);
                chk(16'(seen), 16'h0001);
                if (k == 0)
                begin
                    chk(16'(vec), 16'(!g));
                    idone = 1'b1;
                    step();
                    idone = 1'b0;
                    chk(16'(vec), 16'h0000);
                end
            end
        end
        test_done();
    end
endmodule : rts_sequencer_tb_top
